/* src/eif_top.sv */
// Notes on behaviour
// R01: pins a..c use falling:rising code 00 none, 01 rise, 10 fall, 11 both.
// R02: both upper edge select bytes are 8-bit and reset to zero.
// R03: software clears a pin's select bits before returning it to port use.
// R04: software keeps select bits 00 for pins not used as requests.
// R05: filter enable 0 gives 60 ns analog filtering, 1 gives digital sampling.
// R06: sample clock codes 0..4 divide by 64..1024, 5 is subclock, others prohibited.
// R07: sample count bit 0 needs three equal samples, 1 needs two.
// R08: three-sample filtering rejects pulses up to two sample periods.
// R09: stopped sample clock blocks wake; subclock sampling still wakes from standby.
// R10: after sample clock change software waits, clears pending flag, then enables.
// R11: noise filter control is byte-only and resets to zero, analog.
// R12: requester spaces requests at least five clocks; CPU takes four minimum.
// R13: nmi pin is a port pin after reset; requests need port mode and edge.
// R14: unfiltered pins pass an analog delay before an edge is seen.
// R15: control byte: enable bit 7, count bit 6, zeros 5..3, clock select 2..0.
// R16: new level accepted after configured equal samples; edges detected on it.
`timescale 1ns/10ps
module eif_top (
  // clock and reset
  input wire logic i_sys_clk,
  input wire logic i_rst_b,
  // register port
  input wire logic [31:0] i_addr,
  input wire logic [7:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [7:0] o_rdata,
  // external request pins
  input wire logic i_filtered_request_pin,
  input wire logic i_request_pin_a,
  input wire logic i_request_pin_b,
  input wire logic i_request_pin_c,
  input wire logic i_nmi_pin,
  // power state and subclock
  input wire logic i_standby,
  input wire logic i_subclk,
  // requests to interrupt and dma logic
  output logic [3:0] o_req,
  output logic o_nmi_req,
  output logic o_irq,
  output logic o_wake
);

  typedef struct packed {
    eif_pkg::eif_nfc_type noise_filter_control;
    logic [2:0] fall_hi;
    logic [2:0] rise_hi;
    logic [4:0] edge_ctl;
    logic [4:0] status;
    logic [4:0] mask;
    logic [4:0] lvl_prev;
    logic [3:0] settle;
    logic busy;
    logic [7:0] rdata;
    logic [3:0] req;
    logic nmi;
    logic irq;
    logic wake;
  } eif_top_st_type;

  eif_top_st_type s_q;
  eif_top_st_type s_d;

  logic [4:0] pins;
  logic [4:0] levels;
  logic [4:0] steps;
  logic [3:0] needs [5];
  logic tick;
  logic dig_need_lo;
  logic [3:0] dig_need;

  function automatic logic eif_edge_hit(input logic prev, input logic cur,
                                         input logic fall, input logic rise);
    eif_edge_hit = (rise & cur & ~prev) | (fall & ~cur & prev);
  endfunction : eif_edge_hit

  assign pins = {i_nmi_pin, i_request_pin_c, i_request_pin_b, i_request_pin_a,
                 i_filtered_request_pin};

  // divided sample clock stops with the peripheral clock in standby; subclock ticks continue
  eif_sample_div u_div (
    .i_sys_clk(i_sys_clk),
    .i_rst_b(i_rst_b),
    .i_sel(s_q.noise_filter_control.sel),
    .i_run(~i_standby),
    .i_subclk(i_subclk),
    .o_tick(tick)
  ); // [R06] [R09]

  assign dig_need_lo = s_q.noise_filter_control.two;
  assign dig_need = dig_need_lo ? eif_pkg::EIF_DIG_NEED_2 : eif_pkg::EIF_DIG_NEED_3; // [R07] [R08]

  always_comb begin
    for (int i = 0; i < eif_pkg::EIF_NPIN; i++) begin
      steps[i] = 1'b1;
      needs[i] = eif_pkg::EIF_ANALOG_NEED; // [R14]
    end
    // only the filtered pin can switch to digital sampling
    if (s_q.noise_filter_control.en) begin
      steps[eif_pkg::EIF_PIN_FLT] = tick; // [R05]
      needs[eif_pkg::EIF_PIN_FLT] = dig_need; // [R07]
    end
  end

  for (genvar g = 0; g < eif_pkg::EIF_NPIN; g++) begin : g_flt
    eif_pin_filter u_flt (
      .i_sys_clk(i_sys_clk),
      .i_rst_b(i_rst_b),
      .i_pin(pins[g]),
      .i_step(steps[g]),
      .i_need(needs[g]),
      .o_level(levels[g])
    ); // [R16] [R14]
  end

  always_comb begin
    logic [4:0] rise_sel;
    logic [4:0] fall_sel;
    logic [4:0] hit;
    logic [4:0] clr;
    logic port_ok;
    logic [3:0] nxt_settle;
    rise_sel = '0;
    fall_sel = '0;
    hit = '0;
    clr = '0;
    port_ok = 1'b0;
    nxt_settle = s_q.settle + 4'h1;
    s_d = s_q;

    // nmi is a plain port until port mode is chosen
    port_ok = s_q.edge_ctl[eif_pkg::EIF_CTL_NMI_PORT]; // [R13]
    rise_sel = {s_q.edge_ctl[eif_pkg::EIF_CTL_NMI_RISE] & port_ok, s_q.rise_hi,
                s_q.edge_ctl[eif_pkg::EIF_CTL_FLT_RISE]};
    fall_sel = {s_q.edge_ctl[eif_pkg::EIF_CTL_NMI_FALL] & port_ok, s_q.fall_hi,
                s_q.edge_ctl[eif_pkg::EIF_CTL_FLT_FALL]};

    // edges come from the filtered levels, never the raw pins
    for (int i = 0; i < eif_pkg::EIF_NPIN; i++) begin
      hit[i] = eif_edge_hit(s_q.lvl_prev[i], levels[i], fall_sel[i], rise_sel[i]); // [R01] [R16]
    end
    s_d.lvl_prev = levels;

    // filter settle tracker after a sampling change
    if (s_q.busy && tick) begin
      if (nxt_settle >= dig_need) begin
        s_d.busy = 1'b0;
        s_d.settle = 4'h0;
      end else begin
        s_d.settle = nxt_settle;
      end
    end

    // register writes, byte wide only
    if (i_wr) begin
      unique case (i_addr)
        eif_pkg::EIF_ADDR_NFC: begin
          s_d.noise_filter_control.en = i_wdata[eif_pkg::EIF_NFC_EN_BIT]; // [R05] [R15]
          s_d.noise_filter_control.two = i_wdata[eif_pkg::EIF_NFC_CNT_BIT]; // [R07] [R15]
          s_d.noise_filter_control.zero = 3'h0; // [R15]
          s_d.noise_filter_control.sel = i_wdata[eif_pkg::EIF_NFC_SEL_MSB:0]; // [R06] [R11]
          if (i_wdata[eif_pkg::EIF_NFC_SEL_MSB:0] != s_q.noise_filter_control.sel
              || i_wdata[eif_pkg::EIF_NFC_CNT_BIT] != s_q.noise_filter_control.two) begin
            s_d.busy = 1'b1;
            s_d.settle = 4'h0;
          end
        end
        eif_pkg::EIF_ADDR_FALL_HI: begin
          s_d.fall_hi = i_wdata[7:eif_pkg::EIF_HI_LSB]; // [R01] [R02]
        end
        eif_pkg::EIF_ADDR_RISE_HI: begin
          s_d.rise_hi = i_wdata[7:eif_pkg::EIF_HI_LSB]; // [R01] [R02]
        end
        eif_pkg::EIF_ADDR_EDGE_CTL: begin
          s_d.edge_ctl = i_wdata[4:0]; // [R13]
        end
        eif_pkg::EIF_ADDR_STATUS: begin
          clr = i_wdata[4:0];
        end
        eif_pkg::EIF_ADDR_MASK: begin
          s_d.mask = i_wdata[4:0];
        end
        default: begin
          s_d.mask = s_q.mask;
        end
      endcase
    end

    // a fresh edge wins over a same-cycle clear
    s_d.status = (s_q.status & ~clr) | hit;
    s_d.req = hit[3:0];
    s_d.nmi = hit[eif_pkg::EIF_PIN_NMI]; // [R13]
    s_d.irq = |(s_d.status & s_d.mask);
    // no divided sample ticks in standby means no digital edge and no wake from the filtered pin
    s_d.wake = |hit; // [R09]

    // read data valid the cycle after the strobe only
    s_d.rdata = 8'h00;
    if (i_rd) begin
      unique case (i_addr)
        eif_pkg::EIF_ADDR_NFC: begin
          s_d.rdata = {s_q.noise_filter_control.en, s_q.noise_filter_control.two, 3'h0, s_q.noise_filter_control.sel}; // [R15]
        end
        eif_pkg::EIF_ADDR_FALL_HI: begin
          s_d.rdata = {s_q.fall_hi, 5'h00};
        end
        eif_pkg::EIF_ADDR_RISE_HI: begin
          s_d.rdata = {s_q.rise_hi, 5'h00};
        end
        eif_pkg::EIF_ADDR_EDGE_CTL: begin
          s_d.rdata = {3'h0, s_q.edge_ctl};
        end
        eif_pkg::EIF_ADDR_STATUS: begin
          s_d.rdata = {3'h0, s_q.status};
        end
        eif_pkg::EIF_ADDR_MASK: begin
          s_d.rdata = {3'h0, s_q.mask};
        end
        eif_pkg::EIF_ADDR_LEVEL: begin
          s_d.rdata = {s_q.busy, 2'h0, levels};
        end
        default: begin
          s_d.rdata = 8'h00;
        end
      endcase
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      s_q.noise_filter_control <= '0; // [R11]
      s_q.fall_hi <= eif_pkg::EIF_RST_BYTE[2:0]; // [R02]
      s_q.rise_hi <= eif_pkg::EIF_RST_BYTE[2:0]; // [R02]
      s_q.edge_ctl <= eif_pkg::EIF_RST_PINS; // [R13]
      s_q.status <= eif_pkg::EIF_RST_PINS;
      s_q.mask <= eif_pkg::EIF_RST_PINS;
      s_q.lvl_prev <= eif_pkg::EIF_RST_PINS;
      s_q.settle <= 4'h0;
      s_q.busy <= 1'b0;
      s_q.rdata <= eif_pkg::EIF_RST_BYTE;
      s_q.req <= 4'h0;
      s_q.nmi <= 1'b0;
      s_q.irq <= 1'b0;
      s_q.wake <= 1'b0;
    end else begin
      s_q <= s_d;
    end
  end

  assign o_rdata = s_q.rdata;
  assign o_req = s_q.req;
  assign o_nmi_req = s_q.nmi;
  assign o_irq = s_q.irq;
  assign o_wake = s_q.wake;

endmodule : eif_top

/* src/eif_pkg.sv */
package eif_pkg;

  // clock and analog filter timing
  localparam int unsigned EIF_CLK_MHZ = 250;
  localparam int unsigned EIF_ANALOG_NS = 60;
  localparam int unsigned EIF_ANALOG_CYC = (EIF_ANALOG_NS * EIF_CLK_MHZ + 999) / 1000;
  localparam logic [3:0] EIF_ANALOG_NEED = 4'(EIF_ANALOG_CYC);
  localparam logic [3:0] EIF_DIG_NEED_3 = 4'h3;
  localparam logic [3:0] EIF_DIG_NEED_2 = 4'h2;

  // register addresses
  localparam logic [31:0] EIF_ADDR_NFC = 32'hfffff318;
  localparam logic [31:0] EIF_ADDR_FALL_HI = 32'hfffff320;
  localparam logic [31:0] EIF_ADDR_RISE_HI = 32'hfffff321;
  localparam logic [31:0] EIF_ADDR_EDGE_CTL = 32'hfffff322;
  localparam logic [31:0] EIF_ADDR_STATUS = 32'hfffff324;
  localparam logic [31:0] EIF_ADDR_MASK = 32'hfffff325;
  localparam logic [31:0] EIF_ADDR_LEVEL = 32'hfffff326;

  // reset values
  localparam logic [7:0] EIF_RST_BYTE = 8'h00;
  localparam logic [4:0] EIF_RST_PINS = 5'h00;

  // noise filter control field positions
  localparam int unsigned EIF_NFC_EN_BIT = 7;
  localparam int unsigned EIF_NFC_CNT_BIT = 6;
  localparam int unsigned EIF_NFC_SEL_MSB = 2;

  // upper edge select: pins a..c sit at bits 13..15, bits 5..7 of the byte
  localparam int unsigned EIF_HI_LSB = 5;

  // own edge control register fields
  localparam int unsigned EIF_CTL_NMI_RISE = 0;
  localparam int unsigned EIF_CTL_NMI_FALL = 1;
  localparam int unsigned EIF_CTL_FLT_RISE = 2;
  localparam int unsigned EIF_CTL_FLT_FALL = 3;
  localparam int unsigned EIF_CTL_NMI_PORT = 4;

  // pin order in every 5-bit vector except the edge control register
  localparam int unsigned EIF_NPIN = 5;
  localparam int unsigned EIF_PIN_FLT = 0;
  localparam int unsigned EIF_PIN_NMI = 4;

  // sample clock codes
  localparam logic [2:0] EIF_SCLK_D64 = 3'h0;
  localparam logic [2:0] EIF_SCLK_D128 = 3'h1;
  localparam logic [2:0] EIF_SCLK_D256 = 3'h2;
  localparam logic [2:0] EIF_SCLK_D512 = 3'h3;
  localparam logic [2:0] EIF_SCLK_D1024 = 3'h4;
  localparam logic [2:0] EIF_SCLK_SUB = 3'h5;
  localparam int unsigned EIF_DIV_W = 10;

  typedef struct packed {
    logic en;
    logic two;
    logic [2:0] zero;
    logic [2:0] sel;
  } eif_nfc_type;

endpackage : eif_pkg

/* src/eif_sample_div.sv */
`timescale 1ns/10ps
module eif_sample_div (
  // clock and reset
  input wire logic i_sys_clk,
  input wire logic i_rst_b,
  // control
  input wire logic [2:0] i_sel,
  input wire logic i_run,
  input wire logic i_subclk,
  // sample enable
  output logic o_tick
);

  typedef struct packed {
    logic [eif_pkg::EIF_DIV_W-1:0] cnt;
    logic sub_q;
    logic tick;
  } eif_div_st_type;

  eif_div_st_type s_q;
  eif_div_st_type s_d;

  always_comb begin
    s_d = s_q;
    s_d.sub_q = i_subclk;
    // peripheral clock stops in standby, subclock keeps running
    if (i_run) begin
      s_d.cnt = s_q.cnt + 1'b1;
    end
    unique case (i_sel)
      eif_pkg::EIF_SCLK_D64: s_d.tick = i_run & (&s_q.cnt[5:0]);
      eif_pkg::EIF_SCLK_D128: s_d.tick = i_run & (&s_q.cnt[6:0]);
      eif_pkg::EIF_SCLK_D256: s_d.tick = i_run & (&s_q.cnt[7:0]);
      eif_pkg::EIF_SCLK_D512: s_d.tick = i_run & (&s_q.cnt[8:0]);
      eif_pkg::EIF_SCLK_D1024: s_d.tick = i_run & (&s_q.cnt[9:0]);
      eif_pkg::EIF_SCLK_SUB: s_d.tick = i_subclk & ~s_q.sub_q;
      // prohibited codes never sample
      default: s_d.tick = 1'b0;
    endcase
  end

  always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign o_tick = s_q.tick;

endmodule : eif_sample_div

/* src/eif_pin_filter.sv */
`timescale 1ns/10ps
module eif_pin_filter (
  // clock and reset
  input wire logic i_sys_clk,
  input wire logic i_rst_b,
  // pin and sampling
  input wire logic i_pin,
  input wire logic i_step,
  input wire logic [3:0] i_need,
  // filtered level
  output logic o_level
);

  typedef struct packed {
    logic lvl;
    logic [3:0] cnt;
  } eif_flt_st_type;

  eif_flt_st_type s_q;
  eif_flt_st_type s_d;

  always_comb begin
    logic [3:0] nxt;
    nxt = s_q.cnt + 4'h1;
    s_d = s_q;
    // only sampled values count, so a short glitch between samples is unseen
    if (i_step) begin
      if (i_pin == s_q.lvl) begin
        s_d.cnt = 4'h0;
      end else if (nxt >= i_need) begin
        s_d.lvl = i_pin;
        s_d.cnt = 4'h0;
      end else begin
        s_d.cnt = nxt;
      end
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign o_level = s_q.lvl;

endmodule : eif_pin_filter

/* bench/eif_top_checker.sv */
`timescale 1ns/10ps
module eif_top_checker (
  // clock and reset
  input wire logic i_sys_clk,
  input wire logic i_rst_b,
  // register port
  input wire logic [31:0] i_addr,
  input wire logic [7:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  input wire logic [7:0] o_rdata,
  // pins
  input wire logic i_request_pin_a,
  input wire logic i_nmi_pin,
  // requests
  input wire logic [3:0] o_req,
  input wire logic o_nmi_req,
  input wire logic o_irq,
  input wire logic o_wake
);
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (!i_rst_b);
  a_rdata_idle: assert property (!$past(i_rd) |-> o_rdata == 8'h00)
    else $error("read data outside its cycle");
  a_req_pulse: assert property (o_req != 4'h0 |=> (o_req & $past(o_req)) == 4'h0)
    else $error("request longer than one cycle");
  a_wake_pulse: assert property (o_wake |=> !o_wake)
    else $error("wake longer than one cycle");
  a_wake_on_edge: assert property ((|o_req) || o_nmi_req |-> o_wake)
    else $error("edge without wake");
  a_pin_delay: assert property (o_req[1] |->
    $past(i_request_pin_a, 1) == $past(i_request_pin_a, 16) &&
    $past(i_request_pin_a, 17) != $past(i_request_pin_a, 1))
    else $error("pin a edge without analog delay");
  a_nmi_delay: assert property (o_nmi_req |->
    $past(i_nmi_pin, 1) == $past(i_nmi_pin, 16) &&
    $past(i_nmi_pin, 17) != $past(i_nmi_pin, 1))
    else $error("nmi edge without analog delay");
  a_status_clear: assert property (i_wr && i_addr == eif_pkg::EIF_ADDR_STATUS &&
    i_wdata == 8'h1f |=> !o_irq || (|o_req) || o_nmi_req)
    else $error("irq after status clear");
  a_mask_off: assert property (i_wr && i_addr == eif_pkg::EIF_ADDR_MASK &&
    i_wdata == 8'h00 |-> ##2 !o_irq)
    else $error("irq while fully masked");
  a_irq_cause: assert property ($rose(o_irq) |-> (|o_req) || o_nmi_req || $past(i_wr))
    else $error("irq rose with no cause");
endmodule : eif_top_checker

/* bench/eif_pin_src.sv */
`timescale 1ns/10ps
module eif_pin_src (
  // clock
  input wire logic i_sys_clk,
  // command
  input wire logic i_go,
  input wire logic [4:0] i_sel,
  input wire logic [15:0] i_len,
  // pins
  output logic [4:0] o_pin
);
  logic [15:0] left_q = 16'h0;
  logic [4:0] pin_q = 5'h00;
  assign o_pin = pin_q;
  // unused pins stay low, requests spaced by the bench
  always_ff @(posedge i_sys_clk) begin
    if (i_go) begin
      left_q <= i_len;
      pin_q <= i_sel;
    end else if (left_q != 16'h0) begin
      left_q <= left_q - 16'h1;
      if (left_q == 16'h1) begin
        pin_q <= 5'h00;
      end
    end
  end
endmodule : eif_pin_src

/* bench/eif_top_test.sv */
`timescale 1ns/10ps
module eif_top_test;
  logic i_sys_clk = 1'b0;
  logic i_rst_b = 1'b0;
  logic [31:0] i_addr = 32'h0;
  logic [7:0] i_wdata = 8'h00;
  logic i_wr = 1'b0;
  logic i_rd = 1'b0;
  logic i_standby = 1'b0;
  logic go = 1'b0;
  logic [4:0] sel = 5'h00;
  logic [15:0] len = 16'h0;
  logic [4:0] pin;
  logic [7:0] o_rdata;
  logic [3:0] o_req;
  logic o_nmi_req;
  logic o_irq;
  logic o_wake;
  int fail_count = 0;
  int total_checks = 0;
  int hits[6] = '{0, 0, 0, 0, 0, 0};
  logic [31:0] regs[8] = '{eif_pkg::EIF_ADDR_NFC, eif_pkg::EIF_ADDR_FALL_HI,
    eif_pkg::EIF_ADDR_RISE_HI, eif_pkg::EIF_ADDR_EDGE_CTL, eif_pkg::EIF_ADDR_STATUS,
    eif_pkg::EIF_ADDR_MASK, eif_pkg::EIF_ADDR_LEVEL, 32'hfffff31c};

  eif_top eif_top_inst (.i_sys_clk(i_sys_clk), .i_rst_b(i_rst_b), .i_addr(i_addr),
    .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
    .i_filtered_request_pin(pin[0]), .i_request_pin_a(pin[1]), .i_request_pin_b(pin[2]),
    .i_request_pin_c(pin[3]), .i_nmi_pin(pin[4]), .i_standby(i_standby),
    .i_subclk(1'b0), .o_req(o_req), .o_nmi_req(o_nmi_req), .o_irq(o_irq), .o_wake(o_wake));
  eif_pin_src eif_pin_src_inst (.i_sys_clk(i_sys_clk), .i_go(go), .i_sel(sel),
    .i_len(len), .o_pin(pin));

  initial begin
    forever #2 i_sys_clk = ~i_sys_clk;
  end

  always @(posedge i_sys_clk) begin
    for (int k = 0; k < 4; k++) begin
      if (o_req[k] === 1'b1) hits[k] <= hits[k] + 1;
    end
    if (o_nmi_req === 1'b1) hits[4] <= hits[4] + 1;
    if (o_wake === 1'b1) hits[5] <= hits[5] + 1;
  end

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    total_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask : chk

  task automatic wr(input logic [31:0] a, input logic [7:0] d);
    @(posedge i_sys_clk);
    i_wr <= 1'b1;
    i_addr <= a;
    i_wdata <= d;
    @(posedge i_sys_clk);
    i_wr <= 1'b0;
  endtask : wr

  task automatic rd(input logic [31:0] a, input logic [7:0] e);
    @(posedge i_sys_clk);
    i_rd <= 1'b1;
    i_addr <= a;
    @(posedge i_sys_clk);
    i_rd <= 1'b0;
    #1;
    chk(o_rdata, e);
  endtask : rd

  // e holds two bits of expected request count per pin, wake taken as the largest
  task automatic pulse(input logic [4:0] s, input int w, input logic [9:0] e);
    int base[6];
    int ew;
    base = hits;
    ew = 0;
    @(posedge i_sys_clk);
    sel <= s;
    len <= 16'(w);
    go <= 1'b1;
    @(posedge i_sys_clk);
    go <= 1'b0;
    repeat (2 * w + 700) @(posedge i_sys_clk);
    #1;
    for (int k = 0; k < 5; k++) begin
      chk(8'(hits[k] - base[k]), 8'(e[2*k+:2]));
      if (int'(e[2*k+:2]) > ew) ew = int'(e[2*k+:2]);
    end
    chk(8'(hits[5] - base[5]), 8'(ew));
  endtask : pulse

  task automatic close_out;
    if (fail_count == 0 && total_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : close_out

  initial begin
    #400000;
    fail_count++;
    close_out;
  end

  initial begin
    repeat (20) @(posedge i_sys_clk);
    i_rst_b <= 1'b1;
    foreach (regs[i]) rd(regs[i], 8'h00);
    wr(eif_pkg::EIF_ADDR_NFC, 8'hff);
    rd(eif_pkg::EIF_ADDR_NFC, 8'hc7);
    wr(eif_pkg::EIF_ADDR_FALL_HI, 8'hff);
    rd(eif_pkg::EIF_ADDR_FALL_HI, 8'he0);
    wr(32'hfffff31c, 8'hff);
    rd(32'hfffff31c, 8'h00);
    wr(eif_pkg::EIF_ADDR_NFC, 8'h00);
    rd(eif_pkg::EIF_ADDR_MASK, 8'h00);
    for (int c = 0; c < 4; c++) begin
      wr(eif_pkg::EIF_ADDR_FALL_HI, c[1] ? 8'he0 : 8'h00);
      wr(eif_pkg::EIF_ADDR_RISE_HI, c[0] ? 8'he0 : 8'h00);
      pulse(5'h0e, 30, {2'h0, {3{2'(c[0]) + 2'(c[1])}}, 2'h0});
    end
    pulse(5'h0e, 14, 10'h000);
    rd(eif_pkg::EIF_ADDR_STATUS, 8'h0e);
    chk({7'h0, o_irq}, 8'h00);
    wr(eif_pkg::EIF_ADDR_MASK, 8'hff);
    rd(eif_pkg::EIF_ADDR_MASK, 8'h1f);
    chk({7'h0, o_irq}, 8'h01);
    wr(eif_pkg::EIF_ADDR_STATUS, 8'h1f);
    rd(eif_pkg::EIF_ADDR_STATUS, 8'h00);
    chk({7'h0, o_irq}, 8'h00);
    wr(eif_pkg::EIF_ADDR_MASK, 8'h00);
    wr(eif_pkg::EIF_ADDR_FALL_HI, 8'h00);
    wr(eif_pkg::EIF_ADDR_RISE_HI, 8'h00);
    wr(eif_pkg::EIF_ADDR_EDGE_CTL, 8'h01);
    pulse(5'h10, 30, 10'h000);
    wr(eif_pkg::EIF_ADDR_EDGE_CTL, 8'h15);
    pulse(5'h10, 30, 10'h100);
    pulse(5'h01, 30, 10'h001);
    wr(eif_pkg::EIF_ADDR_NFC, 8'h80);
    repeat (400) @(posedge i_sys_clk);
    pulse(5'h01, 128, 10'h000);
    pulse(5'h01, 600, 10'h001);
    for (int c = 0; c < 5; c++) begin
      wr(eif_pkg::EIF_ADDR_NFC, 8'hc0 | 8'(c));
      repeat (4 * (64 << c)) @(posedge i_sys_clk);
      pulse(5'h01, 64 << c, 10'h000);
      pulse(5'h01, (128 << c) + 4, 10'h001);
    end
    wr(eif_pkg::EIF_ADDR_NFC, 8'h80);
    i_standby <= 1'b1;
    pulse(5'h01, 600, 10'h000);
    i_standby <= 1'b0;
    close_out;
  end
endmodule : eif_top_test

bind eif_top eif_top_checker eif_top_checker_inst (.i_sys_clk(i_sys_clk),
  .i_rst_b(i_rst_b), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd),
  .o_rdata(o_rdata), .i_request_pin_a(i_request_pin_a), .i_nmi_pin(i_nmi_pin),
  .o_req(o_req), .o_nmi_req(o_nmi_req), .o_irq(o_irq), .o_wake(o_wake));
